// File: homing_pkg.sv
// Package for the homing sequencer: method codes, speed and state types.
// Assumes one clock domain; used by homing_sequencer, axis_model and the bench.
package homing_pkg;
	localparam logic [7:0] METHOD_29 = 8'h1D;
	localparam logic [7:0] METHOD_30 = 8'h1E;
	localparam logic [1:0] SPEED_STOP = 2'h0;
	localparam logic [1:0] SPEED_LOW = 2'h1;
	localparam logic [1:0] SPEED_HIGH = 2'h2;
	localparam logic [2:0] STATE_RESET = 3'h0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_REV_HIGH = 3'b001,
		ST_REV_LOW_A = 3'b010,
		ST_FWD_LOW = 3'b011,
		ST_FWD_HIGH = 3'b100,
		ST_REV_LOW_B = 3'b101,
		ST_DONE = 3'b110
	} seq_state_t;

	typedef struct packed {
		logic run;
		logic reverse;
		logic [1:0] speed;
	} motion_cmd_t;

	typedef struct packed {
		logic origin;
		logic rev_limit;
	} switch_in_t;
endpackage

// File: homing_sequencer.sv
// Homing sequencer for one servo axis, methods 29 and the first step of 30.
// Assumes switch inputs already synchronous to clk and debounced upstream.
//
// Overview of operation
// R01 - Method 29 branches on deceleration point validity.
// R02 - 29.1 starts reverse at high speed.
// R03 - Rise slows reverse, fall turns forward, rise stops.
// R04 - 29.2: reverse low, fall fwd low, rise stop.
// R05 - 29.3: limit first gives fwd high, rise fwd low, rise stop.
// R06 - Method 30 invalid point starts reverse high.
// R07 - Method and validity latched at start until stop.
`timescale 1ns/1ps
module homing_sequencer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic abort,
	input wire logic [7:0] method,
	input wire logic decel_valid,
	input wire homing_pkg::switch_in_t sw,
	output homing_pkg::motion_cmd_t cmd,
	output logic busy,
	output logic done,
	output logic limit_seen
);
	homing_pkg::seq_state_t state;
	homing_pkg::seq_state_t next_state;
	logic [7:0] method_q;
	logic valid_q;
	logic origin_q;
	logic rise;
	logic fall;
	logic at_rest;

	// The detector starts low; a false rise after reset is harmless because
	// the idle and finished states never look at origin edges.
	assign rise = sw.origin & ~origin_q;
	assign fall = ~sw.origin & origin_q;
	assign at_rest = state == homing_pkg::ST_IDLE ||
		state == homing_pkg::ST_DONE;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			origin_q <= 1'b0;
		end else begin
			origin_q <= sw.origin;
		end
	end

	// Latching the branch keeps a mid-run parameter change from
	// switching the sequence under a moving axis.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			method_q <= 8'h00;
			valid_q <= 1'b0;
		end else if (start && at_rest) begin
			method_q <= method; // [R07]
			valid_q <= decel_valid; // [R07]
		end
	end

	always_comb begin
		next_state = state;
		unique case (state)
			homing_pkg::ST_IDLE, homing_pkg::ST_DONE: begin
				if (start && (method == homing_pkg::METHOD_29 ||
						method == homing_pkg::METHOD_30)) begin
					if (method == homing_pkg::METHOD_29 && decel_valid) begin
						next_state = homing_pkg::ST_REV_LOW_A; // [R01] [R04]
					end else begin
						next_state = homing_pkg::ST_REV_HIGH; // [R02] [R06]
					end
				end
			end
			homing_pkg::ST_REV_HIGH: begin
				// Method 30 holds its first step; later steps live elsewhere.
				if (method_q == homing_pkg::METHOD_29) begin
					if (rise) begin
						next_state = homing_pkg::ST_REV_LOW_A; // [R03]
					end else if (sw.rev_limit) begin
						next_state = homing_pkg::ST_FWD_HIGH; // [R05]
					end
				end
			end
			homing_pkg::ST_REV_LOW_A: begin
				if (fall) begin
					next_state = homing_pkg::ST_FWD_LOW; // [R03] [R04]
				end
			end
			homing_pkg::ST_FWD_HIGH: begin
				if (rise) begin
					next_state = homing_pkg::ST_FWD_LOW; // [R05]
				end
			end
			homing_pkg::ST_FWD_LOW: begin
				if (rise) begin
					next_state = homing_pkg::ST_DONE; // [R03] [R04] [R05]
				end
			end
			default: begin
				next_state = homing_pkg::ST_IDLE;
			end
		endcase
		if (abort) begin
			next_state = homing_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= homing_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			limit_seen <= 1'b0;
		end else if (state == homing_pkg::ST_REV_HIGH &&
				next_state == homing_pkg::ST_FWD_HIGH) begin
			limit_seen <= 1'b1;
		end else if (next_state == homing_pkg::ST_REV_HIGH) begin
			limit_seen <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmd <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			busy <= next_state != homing_pkg::ST_IDLE &&
				next_state != homing_pkg::ST_DONE;
			done <= next_state == homing_pkg::ST_DONE;
			unique case (next_state)
				homing_pkg::ST_REV_HIGH:
					cmd <= '{1'b1, 1'b1, homing_pkg::SPEED_HIGH};
				homing_pkg::ST_REV_LOW_A, homing_pkg::ST_REV_LOW_B:
					cmd <= '{1'b1, 1'b1, homing_pkg::SPEED_LOW};
				homing_pkg::ST_FWD_HIGH:
					cmd <= '{1'b1, 1'b0, homing_pkg::SPEED_HIGH};
				homing_pkg::ST_FWD_LOW:
					cmd <= '{1'b1, 1'b0, homing_pkg::SPEED_LOW};
				default:
					cmd <= '{1'b0, 1'b0, homing_pkg::SPEED_STOP};
			endcase
		end
	end

	// Abort overrides every transition, so each step check leaves it out.
	// Entry checks cover a restart from the finished state as well.
	a_start_rev_high: assert property (@(posedge clk) // [R06]
		disable iff (!rst_n)
		(at_rest && start && !abort &&
		method == homing_pkg::METHOD_30) |=>
		cmd.run && cmd.reverse && cmd.speed == homing_pkg::SPEED_HIGH)
		else $error("method 30 did not start reverse high");
	a_valid_rev_low: assert property (@(posedge clk) // [R04]
		disable iff (!rst_n)
		(at_rest && start && !abort && decel_valid &&
		method == homing_pkg::METHOD_29) |=>
		cmd.run && cmd.reverse && cmd.speed == homing_pkg::SPEED_LOW)
		else $error("valid point did not start reverse low");
	a_invalid_rev_high: assert property (@(posedge clk) // [R01] [R02]
		disable iff (!rst_n)
		(at_rest && start && !abort && !decel_valid &&
		method == homing_pkg::METHOD_29) |=>
		state == homing_pkg::ST_REV_HIGH && cmd.run && cmd.reverse &&
		cmd.speed == homing_pkg::SPEED_HIGH)
		else $error("invalid point did not start reverse high");
	a_rise_rev_low: assert property (@(posedge clk) // [R03]
		disable iff (!rst_n)
		(state == homing_pkg::ST_REV_HIGH && rise && !abort &&
		method_q == homing_pkg::METHOD_29) |=> cmd.reverse &&
		cmd.speed == homing_pkg::SPEED_LOW)
		else $error("origin rise did not slow reverse");
	a_fall_fwd_low: assert property (@(posedge clk) // [R03]
		disable iff (!rst_n)
		(state == homing_pkg::ST_REV_LOW_A && fall && !abort) |=>
		!cmd.reverse && cmd.speed == homing_pkg::SPEED_LOW)
		else $error("origin fall did not go forward low");
	a_rise_stop: assert property (@(posedge clk) // [R04]
		disable iff (!rst_n)
		(state == homing_pkg::ST_FWD_LOW && rise && !abort) |=>
		!cmd.run && done)
		else $error("origin rise did not stop");
	a_limit_fwd_high: assert property (@(posedge clk) // [R05]
		disable iff (!rst_n)
		(state == homing_pkg::ST_REV_HIGH && !rise && sw.rev_limit &&
		!abort && method_q == homing_pkg::METHOD_29) |=> !cmd.reverse &&
		cmd.speed == homing_pkg::SPEED_HIGH && limit_seen)
		else $error("reverse limit did not turn forward high");
	a_branch_held: assert property (@(posedge clk) // [R07]
		disable iff (!rst_n)
		busy && $past(busy) |-> $stable(method_q) && $stable(valid_q))
		else $error("latched branch changed while homing");
	a_m30_holds: assert property (@(posedge clk) // [R06]
		disable iff (!rst_n)
		(state == homing_pkg::ST_REV_HIGH && !abort &&
		method_q == homing_pkg::METHOD_30) |=> state ==
		homing_pkg::ST_REV_HIGH)
		else $error("method 30 left its first step");
	a_rev_low_hold: assert property (@(posedge clk) // [R04]
		disable iff (!rst_n)
		(state == homing_pkg::ST_REV_LOW_A && !fall && !abort) |=>
		cmd.run && cmd.reverse && cmd.speed == homing_pkg::SPEED_LOW)
		else $error("reverse low left before origin fall");
	a_fwd_high_hold: assert property (@(posedge clk) // [R05]
		disable iff (!rst_n)
		(state == homing_pkg::ST_FWD_HIGH && !rise && !abort) |=>
		cmd.run && !cmd.reverse &&
		cmd.speed == homing_pkg::SPEED_HIGH)
		else $error("forward high left before origin rise");
	a_fwd_high_low: assert property (@(posedge clk) // [R05]
		disable iff (!rst_n)
		(state == homing_pkg::ST_FWD_HIGH && rise && !abort) |=>
		cmd.run && !cmd.reverse && cmd.speed == homing_pkg::SPEED_LOW)
		else $error("origin rise did not slow forward");
	a_fwd_low_hold: assert property (@(posedge clk) // [R03]
		disable iff (!rst_n)
		(state == homing_pkg::ST_FWD_LOW && !rise && !abort) |=>
		cmd.run && !cmd.reverse && cmd.speed == homing_pkg::SPEED_LOW)
		else $error("forward low left before origin rise");
	a_done_stopped: assert property (@(posedge clk) // [R03]
		disable iff (!rst_n)
		done |-> !cmd.run && !busy)
		else $error("axis moving while homing done");
	a_done_held: assert property (@(posedge clk) // [R04]
		disable iff (!rst_n)
		(state == homing_pkg::ST_DONE && !start && !abort) |=>
		done && !cmd.run)
		else $error("finished axis did not stay stopped");
endmodule

// File: axis_model.sv
// Behavioural axis model: position follows the motion command.
// Assumes one clock; origin bands repeat every 64 counts, limit near 0.
`timescale 1ns/1ps
module axis_model (
	input wire logic clk,
	input wire logic load,
	input wire logic signed [31:0] load_pos,
	input wire homing_pkg::motion_cmd_t cmd,
	output homing_pkg::switch_in_t sw
);
	int pos;
	int step;
	// High speed moves two counts a cycle, so no band edge is jumped.
	always_comb begin
		step = (cmd.speed == homing_pkg::SPEED_HIGH) ? 2 : 1;
		if (!cmd.run)
			step = 0;
	end
	always_ff @(posedge clk) begin
		if (load)
			pos <= load_pos;
		else
			pos <= cmd.reverse ? pos - step : pos + step;
	end
	assign sw.origin = (pos % 64) >= 32 && (pos % 64) < 48;
	assign sw.rev_limit = pos <= 4;
endmodule

// File: homing_sequencer_bench.sv
// Self-checking bench for the homing sequencer against the axis model.
// Assumes a 100 MHz clock and synchronous active-low reset.
`timescale 1ns/1ps
`define CHECK(a, b) begin total_checks++; if ((a) !== (b)) begin \
num_errors++; $display("wrong value at %0t: %h %h", $time, a, b); end end
module homing_sequencer_bench;
	localparam logic [3:0] RH = {2'b11, homing_pkg::SPEED_HIGH};
	localparam logic [3:0] RL = {2'b11, homing_pkg::SPEED_LOW};
	localparam logic [3:0] FH = {2'b10, homing_pkg::SPEED_HIGH};
	localparam logic [3:0] FL = {2'b10, homing_pkg::SPEED_LOW};
	logic clk = 0, rst_n = 0, start = 0, abort = 0, dv = 0, load = 0;
	logic [7:0] method = 0;
	logic signed [31:0] load_pos = 0;
	homing_pkg::motion_cmd_t cmd;
	homing_pkg::switch_in_t sw;
	logic busy, done, limit_seen;
	logic [3:0] last;
	int num_errors = 0, total_checks = 0, cycles = 0;
	homing_sequencer homing_sequencer_i (.clk(clk), .rst_n(rst_n),
		.start(start), .abort(abort), .method(method), .decel_valid(dv),
		.sw(sw), .cmd(cmd), .busy(busy), .done(done),
		.limit_seen(limit_seen));
	axis_model axis_model_i (.clk(clk), .load(load), .load_pos(load_pos),
		.cmd(cmd), .sw(sw));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			conclude();
		end
	end
	task conclude;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Changing method and validity after start shows the branch is latched.
	task go(input logic [7:0] m, input logic v, input int p);
		@(posedge clk);
		load <= 1;
		load_pos <= p;
		method <= m;
		dv <= v;
		@(posedge clk);
		load <= 0;
		start <= 1;
		@(posedge clk);
		start <= 0;
		dv <= ~v;
		method <= 8'h00;
		last = 4'h0;
	endtask
	task step(input logic [3:0] e);
		int n;
		n = 0;
		@(negedge clk);
		while (cmd === last && n < 400) begin
			@(negedge clk);
			n++;
		end
		`CHECK(cmd, e)
		last = cmd;
	endtask
	task t29_1;
		go(homing_pkg::METHOD_29, 0, 56);
		step(RH);
		step(RL);
		step(FL);
		step(4'h0);
		`CHECK(done, 1'b1)
		`CHECK(limit_seen, 1'b0)
		$display("test t29_1 done");
	endtask
	task t29_2;
		go(homing_pkg::METHOD_29, 1, 40);
		step(RL);
		step(FL);
		step(4'h0);
		`CHECK(sw.origin, 1'b1)
		$display("test t29_2 done");
	endtask
	task t29_3;
		go(homing_pkg::METHOD_29, 0, 20);
		step(RH);
		step(FH);
		`CHECK(limit_seen, 1'b1)
		step(FL);
		step(4'h0);
		`CHECK(done, 1'b1)
		$display("test t29_3 done");
	endtask
	task t30;
		go(homing_pkg::METHOD_30, 0, 56);
		step(RH);
		repeat (20) @(negedge clk);
		`CHECK(cmd, RH)
		`CHECK(busy, 1'b1)
		@(posedge clk);
		abort <= 1;
		@(posedge clk);
		abort <= 0;
		@(negedge clk);
		`CHECK(busy, 1'b0)
		$display("test t30 done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1;
		t29_1();
		t29_2();
		t29_3();
		t30();
		conclude();
	end
endmodule
